// File: rtl/plcc_top.sv
// pll lock, sleep gating and deep-sleep clock switching controller
// Function
// R1: pll disabled after power-on reset
// R2: pll vco halved before divisor applied
// R3: crystal change updates translation output
// R4: power-down disables pll and its output
// R5: crystal value change starts relock
// R6: power-down to normal starts relock
// R7: relock counter loads 0x1200, oscillator ticked
// R8: pll unusable as clock until relock done
// R9: pll selected early stays on oscillator
// R10: raw lock flag plus maskable lock interrupt
// R11: run mode clocks core and run-gated peripherals
// R12: sleep stops core, gates sleep/run by auto
// R13: sleep keeps run clock source and frequency
// R14: deep sleep stops core, gates deep/run
// R15: deep sleep uses main or chosen oscillator
// R16: deep sleep powers pll down, overrides divisor
// R17: deep exit restores clock before enabling gates
// R18: core requests sleep, interrupt returns run
// R19: core sets deep bit then waits
// R20: extended config used only with override bit
// R21: software sequences bypass, config, lock, unbypass
// R22: clearing power-down powers pll and output
// R23: divisor equals divider field plus one
// R24: extended divider two bits wider, to /64
// R25: relock clears lock flag, expiry sets it
// R26: new cause reloads running relock counter
`timescale 1ns/10ps
module plcc_top
  import plcc_pkg::*;
(
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  input  wire plcc_rcc_s                   rcc_cfg,
  input  wire plcc_run_clock_config_ext_s                  run_clock_config_ext_cfg,
  input  wire plcc_dslp_s                  dslp_cfg,
  input  wire logic [`PLCC_NPERIPH-1:0]    run_gate_regs,
  input  wire logic [`PLCC_NPERIPH-1:0]    sleep_gate_regs,
  input  wire logic [`PLCC_NPERIPH-1:0]    deepsleep_gate_regs,
  input  wire logic                        sleep_req,
  input  wire logic                        sleep_deep,
  input  wire logic                        wake_event,
  input  wire logic                        mosc_tick_pin,
  input  wire logic                        lock_int_mask,
  output logic [`PLCC_TRANS_W-1:0]         pll_translation_reg,
  output logic                             pll_power_on,
  output logic                             pll_out_en,
  output logic                             pll_lock_raw_flag,
  output logic                             pll_lock_int,
  output plcc_clk_s                        sys_clk,
  output logic                             cpu_clk_en,
  output logic                             mem_clk_en,
  output logic [`PLCC_NPERIPH-1:0]         periph_clk_en,
  output logic                             mosc_power_on,
  output logic                             iosc_power_on,
  output plcc_mode_e                       power_mode
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  plcc_mode_e                mode_q;          // current power mode
  plcc_mode_e                mode_d;          // next power mode
  logic                      tick_meta_q;     // oscillator sync stage 1
  logic                      tick_sync_q;     // oscillator sync stage 2
  logic                      tick_prev_q;     // for rising edge detect
  logic                      osc_tick;        // one oscillator period
  logic [`PLCC_CRYSTAL_SELECT_W-1:0]   crystal_select_q;          // last seen crystal code
  logic                      pll_on_q;        // pll powered last cycle
  logic                      pll_at_entry_q;  // pll ran when deep began
  logic                      raw_q;           // raw lock flag
  logic                      int_q;           // masked lock interrupt
  logic [`PLCC_TRANS_W-1:0]  trans_q;         // crystal translation
  plcc_clk_s                 clk_q;           // registered clock choice
  plcc_clk_s                 clk_d;
  logic                      cpu_en_q;        // core and memory clock
  logic [`PLCC_NPERIPH-1:0]  gate_q;          // peripheral clock gates
  logic [`PLCC_NPERIPH-1:0]  gate_d;
  logic                      mosc_on_q;       // main oscillator power
  logic                      iosc_on_q;       // internal osc power
  logic                      eff_bypass;      // effective bypass
  logic                      eff_pd;          // effective power-down
  logic [`PLCC_DIV_EXT_W-1:0] eff_div;        // effective divider
  logic [2:0]                eff_osc;         // effective osc source
  logic                      pll_want;        // pll should be powered
  logic                      relock_start;    // a relock cause this cycle
  logic                      ctr_done;        // relock wait is over
  logic                      locked;          // pll usable as a clock
  logic                      use_pll;         // clock from pll now
  logic                      ds_internal;     // deep sleep on internal osc

  // ****************************************************************
  // effective configuration
  // ****************************************************************
  // extended fields only count while the override bit is set
  always_comb
  begin
    if (run_clock_config_ext_cfg.use_ext_config)  // R20
    begin
      eff_bypass = run_clock_config_ext_cfg.bypass;
      eff_pd     = run_clock_config_ext_cfg.pll_powerdown;
      eff_div    = run_clock_config_ext_cfg.sys_divider_ext;  // R24
      eff_osc    = run_clock_config_ext_cfg.osc_source;
    end
    else
    begin
      eff_bypass = rcc_cfg.bypass;
      eff_pd     = rcc_cfg.pll_powerdown;
      eff_div    = {2'b00, rcc_cfg.sys_divider};
      eff_osc    = {1'b0, rcc_cfg.osc_source};
    end
  end

  // ****************************************************************
  // oscillator tick synchroniser
  // ****************************************************************
  // the main oscillator is a foreign clock, sampled as a level
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick_meta_q <= 1'b0;
      tick_sync_q <= 1'b0;
      tick_prev_q <= 1'b0;
    end
    else
    begin
      tick_meta_q <= mosc_tick_pin;
      tick_sync_q <= tick_meta_q;
      tick_prev_q <= tick_sync_q;
    end
  end

  assign osc_tick = tick_sync_q && !tick_prev_q;

  // ****************************************************************
  // relock causes
  // ****************************************************************
  // deep sleep forces the pll down; leaving it is a normal relock
  assign pll_want     = !eff_pd && (mode_d != PLCC_DEEP);  // R4 R16 R22
  // a rewrite with the same crystal code does not restart the wait
  assign relock_start = (rcc_cfg.crystal_select != crystal_select_q)  // R5
                        || (pll_want && !pll_on_q);          // R6
  assign locked       = ctr_done && pll_on_q && pll_want;  // R4
  // a cause in this very cycle already makes the pll unusable
  assign use_pll      = !eff_bypass && locked && !relock_start;  // R8 R9

  plcc_relock_ctr u_relock
  (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .start    (relock_start),
    .osc_tick (osc_tick),
    .done     (ctr_done),
    .count    ()
  );

  // crystal tracking and translation
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      crystal_select_q  <= `PLCC_CRYSTAL_SELECT_RST;
      trans_q <= {`PLCC_CRYSTAL_SELECT_RST, `PLCC_TRANS_FB};
    end
    else
    begin
      crystal_select_q  <= rcc_cfg.crystal_select;
      trans_q <= {rcc_cfg.crystal_select, `PLCC_TRANS_FB};  // R3 R22
    end
  end

  // pll power state, off out of reset
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      pll_on_q <= 1'b0;  // R1
    else
      pll_on_q <= pll_want;  // R4 R22
  end

  // ****************************************************************
  // lock flag and interrupt
  // ****************************************************************
  // a relock clear beats expiry: a stale lock must never be seen
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      raw_q <= 1'b0;
      int_q <= 1'b0;
    end
    else
    begin
      if (relock_start)
        raw_q <= 1'b0;  // R25
      else if (locked)
        raw_q <= 1'b1;  // R25
      int_q <= !relock_start && (locked || raw_q)  // R10
               && lock_int_mask;
    end
  end

  // ****************************************************************
  // power mode sequencer
  // ****************************************************************
  // restore holds the core clock off and the deep-sleep gating one cycle after the clock is put back
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      PLCC_RUN:
        if (sleep_req && !wake_event)  // R18 R19
          mode_d = sleep_deep ? PLCC_DEEP : PLCC_SLEEP;
      PLCC_SLEEP:
        if (wake_event)
          mode_d = PLCC_RUN;  // R18
      PLCC_DEEP:
        if (wake_event)
          mode_d = PLCC_RESTORE;  // R17
      PLCC_RESTORE:
        mode_d = PLCC_RUN;  // R17
      default:
        mode_d = PLCC_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      mode_q <= PLCC_RUN;
    else
      mode_q <= mode_d;
  end

  // remember whether the pll was running when deep sleep began
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      pll_at_entry_q <= 1'b0;
    else if (mode_q == PLCC_RUN && mode_d == PLCC_DEEP)
      pll_at_entry_q <= pll_on_q;  // R16
  end

  // ****************************************************************
  // system clock source and divisor
  // ****************************************************************
  assign ds_internal = (dslp_cfg.osc_source != `PLCC_OSC_MAIN);

  // sleep and restore use the run selection, so the frequency holds
  always_comb
  begin
    clk_d.src_pll    = use_pll;  // R11 R13
    clk_d.prediv2    = use_pll;  // R2
    clk_d.osc_source = eff_osc;
    if (rcc_cfg.use_sys_divider || use_pll)
      clk_d.divisor = 7'(eff_div) + `PLCC_DIV_ONE;  // R23
    else
      clk_d.divisor = `PLCC_DIV_ONE;
    if (mode_d == PLCC_DEEP)
    begin
      clk_d.src_pll    = 1'b0;  // R16
      clk_d.prediv2    = 1'b0;
      clk_d.osc_source = ds_internal ? dslp_cfg.osc_source  // R15
                                     : `PLCC_OSC_MAIN;
      if (pll_at_entry_q || (mode_q == PLCC_RUN && pll_on_q))
      begin
        // base register reaches /16, extended one /64
        if (run_clock_config_ext_cfg.use_ext_config)
          clk_d.divisor = 7'(dslp_cfg.deepsleep_div_override)
                          + `PLCC_DIV_ONE;  // R16
        else
          clk_d.divisor = 7'(dslp_cfg.deepsleep_div_override[3:0])
                          + `PLCC_DIV_ONE;  // R16
      end
    end
  end

  // ****************************************************************
  // clock gating
  // ****************************************************************
  // restore keeps the deep-sleep gating for one cycle after the clock is back
  always_comb
  begin
    case (mode_d)
      PLCC_RUN:
        gate_d = run_gate_regs;  // R11
      PLCC_SLEEP:
        gate_d = rcc_cfg.auto_gate ? sleep_gate_regs  // R12
                                   : run_gate_regs;
      PLCC_DEEP,
      PLCC_RESTORE:
        gate_d = rcc_cfg.auto_gate ? deepsleep_gate_regs  // R14 R17
                                   : run_gate_regs;
      default:
        gate_d = run_gate_regs;
    endcase
  end

  // registered clock outputs
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clk_q     <= '0;
      cpu_en_q  <= 1'b1;
      gate_q    <= '0;
      mosc_on_q <= 1'b1;
      iosc_on_q <= 1'b0;
    end
    else
    begin
      clk_q     <= clk_d;
      cpu_en_q  <= (mode_d == PLCC_RUN);  // R11 R12 R14 R17
      gate_q    <= gate_d;
      // deep sleep on an internal oscillator parks the main one
      mosc_on_q <= !(mode_d == PLCC_DEEP && ds_internal);  // R15
      iosc_on_q <= (mode_d == PLCC_DEEP && ds_internal)  // R15
                   || (mode_d != PLCC_DEEP && eff_osc != `PLCC_OSC_MAIN);
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign pll_translation_reg = trans_q;
  assign pll_power_on        = pll_on_q;
  assign pll_out_en          = pll_on_q;  // R4 R22
  assign pll_lock_raw_flag   = raw_q;
  assign pll_lock_int        = int_q;
  assign sys_clk             = clk_q;
  assign cpu_clk_en          = cpu_en_q;
  assign mem_clk_en          = cpu_en_q;
  assign periph_clk_en       = gate_q;
  assign mosc_power_on       = mosc_on_q;
  assign iosc_power_on       = iosc_on_q;
  assign power_mode          = mode_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_deep_exit;
    (power_mode == PLCC_DEEP) ##1 (power_mode == PLCC_RESTORE);
  endsequence

  a_no_pll_unlocked: assert property (  // R8
    @(posedge ref_clk) disable iff (!arst_n)
    sys_clk.src_pll |-> pll_lock_raw_flag && pll_power_on)
    else $error("pll used as clock without lock");

  a_pd_no_out: assert property (  // R4
    @(posedge ref_clk) disable iff (!arst_n)
    !pll_power_on |-> !pll_out_en && !sys_clk.src_pll)
    else $error("pll drives output while powered down");

  a_crystal_select_relock: assert property (  // R5
    @(posedge ref_clk) disable iff (!arst_n)
    (rcc_cfg.crystal_select != $past(rcc_cfg.crystal_select))
    |=> !pll_lock_raw_flag)
    else $error("crystal change did not clear lock");

  a_deep_exit_order: assert property (  // R17
    @(posedge ref_clk) disable iff (!arst_n)
    s_deep_exit |-> !cpu_clk_en ##1 cpu_clk_en)
    else $error("deep exit did not enable clocks after restore");

  a_sleep_gating: assert property (  // R12
    @(posedge ref_clk) disable iff (!arst_n)
    (power_mode == PLCC_SLEEP) |-> !cpu_clk_en && periph_clk_en ==
      ($past(rcc_cfg.auto_gate) ? $past(sleep_gate_regs)
                                : $past(run_gate_regs)))
    else $error("sleep gating wrong");

  a_deep_gating: assert property (  // R14
    @(posedge ref_clk) disable iff (!arst_n)
    (power_mode == PLCC_DEEP) |-> !mem_clk_en && periph_clk_en ==
      ($past(rcc_cfg.auto_gate) ? $past(deepsleep_gate_regs)
                                : $past(run_gate_regs)))
    else $error("deep sleep gating wrong");

  a_deep_pll_off: assert property (  // R16
    @(posedge ref_clk) disable iff (!arst_n)
    (power_mode == PLCC_DEEP) |-> !pll_power_on && !sys_clk.prediv2)
    else $error("pll running in deep sleep");

  a_wake_run: assert property (  // R18
    @(posedge ref_clk) disable iff (!arst_n)
    (power_mode == PLCC_SLEEP && wake_event)
    |=> (power_mode == PLCC_RUN) && cpu_clk_en)
    else $error("wake did not return to run");

  a_int_mask: assert property (  // R10
    @(posedge ref_clk) disable iff (!arst_n)
    pll_lock_int |-> pll_lock_raw_flag && $past(lock_int_mask))
    else $error("lock interrupt without flag or mask");
endmodule

// File: rtl/plcc_cfg.svh
// constants for the pll lock and sleep clock controller
`ifndef PLCC_CFG_SVH
`define PLCC_CFG_SVH

// ****************************************************************
// widths
// ****************************************************************
`define PLCC_NPERIPH      32
`define PLCC_CRYSTAL_SELECT_W       5
`define PLCC_DIV_W        4
`define PLCC_DIV_EXT_W    6
`define PLCC_DIVISOR_W    7
`define PLCC_TRANS_W      14
`define PLCC_RELOCK_W     13

// ****************************************************************
// timing and reset values
// ****************************************************************
// relock wait in main oscillator periods (about 562 us at 8.192 MHz)
`define PLCC_RELOCK_LOAD  13'h1200
`define PLCC_RELOCK_ZERO  13'h0000
// pll vco runs at 400 MHz and is always halved before the divisor
`define PLCC_VCO_MHZ      400
`define PLCC_CRYSTAL_SELECT_RST     5'h0b
// feedback part of the crystal translation, value is arbitrary
`define PLCC_TRANS_FB     9'h0c8
`define PLCC_DIV_ONE      7'h01
`define PLCC_OSC_MAIN     3'h0

`endif

// File: rtl/plcc_pkg.sv
// types shared by the pll lock and sleep clock controller
package plcc_pkg;
  `include "plcc_cfg.svh"

  // ****************************************************************
  // power modes of the controller
  // ****************************************************************
  typedef enum logic [1:0]
  {
    PLCC_RUN,
    PLCC_SLEEP,
    PLCC_DEEP,
    PLCC_RESTORE
  } plcc_mode_e;

  // base run-mode clock configuration
  typedef struct packed
  {
    logic [`PLCC_CRYSTAL_SELECT_W-1:0] crystal_select;
    logic [1:0]              osc_source;
    logic                    bypass;
    logic                    use_sys_divider;
    logic [`PLCC_DIV_W-1:0]  sys_divider;
    logic                    pll_powerdown;
    logic                    auto_gate;
  } plcc_rcc_s;

  // extended run-mode clock configuration
  typedef struct packed
  {
    logic                       use_ext_config;
    logic [2:0]                 osc_source;
    logic                       bypass;
    logic [`PLCC_DIV_EXT_W-1:0] sys_divider_ext;
    logic                       pll_powerdown;
  } plcc_run_clock_config_ext_s;

  // deep-sleep clock configuration
  typedef struct packed
  {
    logic [`PLCC_DIV_EXT_W-1:0] deepsleep_div_override;
    logic [2:0]                 osc_source;
  } plcc_dslp_s;

  // system clock selection handed to the clock tree
  typedef struct packed
  {
    logic                       src_pll;
    logic                       prediv2;
    logic [`PLCC_DIVISOR_W-1:0] divisor;
    logic [2:0]                 osc_source;
  } plcc_clk_s;
endpackage

// File: rtl/plcc_relock_ctr.sv
// relock wait down counter ticked by the main oscillator
`timescale 1ns/10ps
module plcc_relock_ctr
  import plcc_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      arst_n,
  input  wire logic                      start,
  input  wire logic                      osc_tick,
  output logic                           done,
  output logic [`PLCC_RELOCK_W-1:0]      count
);

  // ****************************************************************
  // counter
  // ****************************************************************
  logic [`PLCC_RELOCK_W-1:0] count_q;  // remaining oscillator ticks
  logic                      done_q;   // wait over since last start

  // a new start reloads even while running, so the wait restarts
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_q <= `PLCC_RELOCK_ZERO;
      done_q  <= 1'b0;  // pll is off after reset, nothing locked
    end
    else if (start)
    begin
      count_q <= `PLCC_RELOCK_LOAD;  // R7 R26
      done_q  <= 1'b0;
    end
    else if (osc_tick && count_q != `PLCC_RELOCK_ZERO)
    begin
      count_q <= count_q - 13'h0001;  // R7
      done_q  <= (count_q == 13'h0001);
    end
  end

  assign done  = done_q;
  assign count = count_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_relock_load: assert property (  // R7
    @(posedge ref_clk) disable iff (!arst_n)
    start |=> (count == `PLCC_RELOCK_LOAD) && !done)
    else $error("relock counter not loaded on start");

  a_done_hold: assert property (  // R8
    @(posedge ref_clk) disable iff (!arst_n)
    (count != `PLCC_RELOCK_ZERO) |-> !done)
    else $error("relock done while counter still running");
endmodule

// File: sim/plcc_core_model.sv
// model of the core side: sleep requests and the main oscillator
`timescale 1ns/10ps
module plcc_core_model
(
  input  wire logic ref_clk,
  output logic      sleep_req,
  output logic      sleep_deep,
  output logic      mosc_tick_pin
);
  // main oscillator runs free, 20 ns period, edges off the ref_clk rise
  initial
  begin
    mosc_tick_pin = 1'b0;
    forever #10 mosc_tick_pin = ~mosc_tick_pin;
  end

  // core idle until told otherwise
  initial
  begin
    sleep_req = 1'b0;
    sleep_deep = 1'b0;
  end

  // deep bit goes out a cycle ahead of the wait request
  task automatic request(input logic deep);
    @(negedge ref_clk);
    sleep_deep = deep;
    @(negedge ref_clk);
    sleep_req = 1'b1;
    @(negedge ref_clk);
    sleep_req = 1'b0;
  endtask
endmodule

// File: sim/plcc_top_bench.sv
// self-checking bench for the pll lock and sleep clock controller
`timescale 1ns/10ps
module plcc_top_bench;
  import plcc_pkg::*;
  // one run-mode case: divider, its enable, source, run gates
  typedef struct packed
  {
    logic [3:0]  dv;
    logic        us;
    logic [1:0]  os;
    logic [31:0] g;
  } plcc_row_s;
  plcc_row_s   rows [3] = '{'{4'hf, 1'b1, 2'h0, 32'hffff_ffff},
                            '{4'h0, 1'b1, 2'h1, 32'h0000_0000},
                            '{4'h7, 1'b0, 2'h0, 32'h0000_00f1}};
  logic        ref_clk;
  logic        arst_n;
  plcc_rcc_s   run_clock_config;
  plcc_run_clock_config_ext_s  run_clock_config_ext;
  plcc_dslp_s  dslp;
  logic [31:0] rg;
  logic [31:0] sg;
  logic [31:0] dg;
  logic        wake;
  logic        mask;
  logic        sreq;
  logic        sdeep;
  logic        mosc;
  logic [13:0] trans;
  logic        pwr;
  logic        outen;
  logic        flag;
  logic        lint;
  plcc_clk_s   sclk;
  logic        cpu;
  logic        mem;
  logic [31:0] periph;
  logic        mpwr;
  logic        ipwr;
  plcc_mode_e  pm;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;

  plcc_top plcc_top_i (.ref_clk(ref_clk), .arst_n(arst_n), .rcc_cfg(run_clock_config),
    .run_clock_config_ext_cfg(run_clock_config_ext), .dslp_cfg(dslp), .run_gate_regs(rg),
    .sleep_gate_regs(sg), .deepsleep_gate_regs(dg), .sleep_req(sreq),
    .sleep_deep(sdeep), .wake_event(wake), .mosc_tick_pin(mosc),
    .lock_int_mask(mask), .pll_translation_reg(trans), .pll_power_on(pwr),
    .pll_out_en(outen), .pll_lock_raw_flag(flag), .pll_lock_int(lint),
    .sys_clk(sclk), .cpu_clk_en(cpu), .mem_clk_en(mem),
    .periph_clk_en(periph), .mosc_power_on(mpwr), .iosc_power_on(ipwr),
    .power_mode(pm));

  plcc_core_model plcc_core_model_i (.ref_clk(ref_clk), .sleep_req(sreq),
    .sleep_deep(sdeep), .mosc_tick_pin(mosc));

  // 200 MHz reference clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ceiling well above two relock waits of about 18.4k cycles each
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      final_report();
    end
  end

  // compare and count; x or z never matches
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // 0x1200 ticks of 4 cycles each, plus sync slack
  task automatic wait_lock();
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 20000)
    begin
      @(negedge ref_clk);
      n++;
      if (n == 100)
      begin
        chk("early src_pll", 0, sclk.src_pll);
        chk("flag in wait", 0, flag);
      end
    end
    chk("lock window", 1, n >= 18400 && n <= 18480);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    run_clock_config = '0;
    run_clock_config_ext = '0;
    run_clock_config.crystal_select = 5'h0b;
    run_clock_config.pll_powerdown = 1'b1;
    run_clock_config.bypass = 1'b1;
    dslp = '0;
    rg = 32'h0000_00f1;
    sg = 32'h0000_0f02;
    dg = 32'h0000_f004;
    wake = 1'b0;
    mask = 1'b1;
    arst_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    arst_n = 1'b1;
    chk("power at reset", 0, pwr);
    chk("trans at reset", {5'h0b, 9'h0c8}, trans);
    $display("test reset done");
    // run-mode cases, pll bypassed
    foreach (rows[i])
    begin
      run_clock_config.sys_divider = rows[i].dv;
      run_clock_config.use_sys_divider = rows[i].us;
      run_clock_config.osc_source = rows[i].os;
      rg = rows[i].g;
      repeat (3) @(negedge ref_clk);
      chk("divisor", rows[i].us ? rows[i].dv + 7'h01 : 7'h01, sclk.divisor);
      chk("osc", rows[i].os, sclk.osc_source);
      chk("run gates", rows[i].g, periph);
      chk("cpu clock", 1, cpu);
    end
    $display("test rows done");
    // enable and select the pll in one step
    run_clock_config.sys_divider = 4'h3;
    run_clock_config.use_sys_divider = 1'b1;
    run_clock_config.pll_powerdown = 1'b0;
    run_clock_config.bypass = 1'b0;
    wait_lock();
    chk("src_pll", 1, sclk.src_pll);
    chk("prediv2", 1, sclk.prediv2);
    chk("pll divisor", 4, sclk.divisor);
    chk("pll power", 1, pwr);
    chk("pll output", 1, outen);
    chk("lock int", 1, lint);
    mask = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("masked int", 0, lint);
    mask = 1'b1;
    run_clock_config.crystal_select = 5'h0b;
    repeat (5) @(negedge ref_clk);
    chk("same crystal", 1, flag);
    run_clock_config.crystal_select = 5'h10;
    repeat (1000) @(negedge ref_clk);
    chk("flag cleared", 0, flag);
    chk("translation", {5'h10, 9'h0c8}, trans);
    run_clock_config.crystal_select = 5'h11;
    wait_lock();
    $display("test relock done");
    // sleep with auto gating keeps the run clock
    run_clock_config.auto_gate = 1'b1;
    plcc_core_model_i.request(1'b0);
    chk("sleep mode", PLCC_SLEEP, pm);
    chk("sleep cpu", 0, cpu);
    chk("sleep mem", 0, mem);
    chk("sleep gates", sg, periph);
    chk("sleep clock", {1'b1, 1'b1, 7'h04, 3'h0}, sclk);
    wake = 1'b1;
    @(negedge ref_clk);
    wake = 1'b0;
    chk("woken", PLCC_RUN, pm);
    $display("test sleep done");
    // deep sleep onto an internal oscillator with the pll running
    dslp.deepsleep_div_override = 6'h05;
    dslp.osc_source = 3'h1;
    plcc_core_model_i.request(1'b1);
    chk("deep mode", PLCC_DEEP, pm);
    chk("deep pll off", 0, pwr);
    chk("deep clock", {1'b0, 7'h06, 3'h1}, sclk[10:0]);
    chk("deep osc power", 2'b01, {mpwr, ipwr});
    chk("deep gates", dg, periph);
    chk("deep cpu", 0, cpu);
    wake = 1'b1;
    @(negedge ref_clk);
    wake = 1'b0;
    chk("restore mode", PLCC_RESTORE, pm);
    chk("restore clock", {1'b0, 7'h04, 3'h0}, {sclk.src_pll, sclk[9:0]});
    chk("restore cpu", 0, cpu);
    @(negedge ref_clk);
    chk("run again", PLCC_RUN, pm);
    chk("run gates back", rg, periph);
    $display("test deep done");
    // extended config only counts while its override bit is set
    run_clock_config_ext.sys_divider_ext = 6'h3f;
    repeat (2) @(negedge ref_clk);
    chk("ext ignored", 7'h04, sclk.divisor);
    run_clock_config_ext.use_ext_config = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("ext divisor", 7'h40, sclk.divisor);
    $display("test ext done");
    // reset again in mid-run, then release it
    arst_n = 1'b0;
    #1;
    chk("reset power", 0, pwr);
    chk("reset flag", 0, flag);
    @(negedge ref_clk);
    arst_n = 1'b1;
    @(negedge ref_clk);
    chk("power after reset", 1, pwr);
    chk("flag after reset", 0, flag);
    chk("no pll after reset", 0, sclk.src_pll);
    $display("test mid reset done");
    final_report();
  end
endmodule
